// ==== src/gpi_pkg.sv ====
package gpi_pkg;
   // ------------------------------------------------------------
   // register offsets (byte addresses)
   // ------------------------------------------------------------
   localparam logic [11:0] OFF_SENSE = 12'h0404;
   localparam logic [11:0] OFF_BOTH = 12'h0408;
   localparam logic [11:0] OFF_POL = 12'h040c;
   localparam logic [11:0] OFF_MASK = 12'h0410;
   localparam logic [11:0] OFF_RAW = 12'h0414;
   localparam logic [11:0] OFF_MSTAT = 12'h0418;
   localparam logic [11:0] OFF_CLR = 12'h041c;
   localparam logic [11:0] OFF_FSEL = 12'h0420;
   // ------------------------------------------------------------
   // reset values and widths
   // ------------------------------------------------------------
   localparam int PIN_W = 8;
   localparam logic [7:0] RST_CFG = 8'h00;
   localparam logic [7:0] RST_FSEL_DEF = 8'h00;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ------------------------------------------------------------
   // carrier for per-pin configuration
   // ------------------------------------------------------------
   typedef struct packed {
      logic [7:0] sense;
      logic [7:0] both;
      logic [7:0] pol;
      logic [7:0] mask;
   } gpi_cfg_t;
endpackage

// ==== src/gpi_irq_port.sv ====
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
// Overview of operation
// - sense bit one selects level, zero edge
// - both-edges bit ignores polarity for edges
// - both-edges set: every edge raises condition
// - polarity one: rising edge or high level
// - polarity zero: falling edge or low level
// - mask one passes condition to interrupts
// - mask zero blocks, raw still records
// - raw bit reads one once detected
// - raw bit reads zero otherwise
// - masked status equals raw and mask
// - masked reads zero if none or masked
// - clear write one resets edge latch
// - clear write zero leaves state alone
// - function select one gives hardware control
// - after reset pins software inputs
// - debug pins reset to hardware function
// - any reset restores default selects
module gpi_irq_port #(
   parameter int PINS = gpi_pkg::PIN_W,
   parameter logic [7:0] FSEL_RESET = gpi_pkg::RST_FSEL_DEF
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // pins and control
   input wire logic [PINS-1:0] pin_in,
   output logic [PINS-1:0] hw_control_bits,
   output logic [PINS-1:0] pin_irq,
   output logic port_combined_irq
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   gpi_pkg::gpi_cfg_t cfg_ff;
   logic [PINS-1:0] fsel_ff;
   logic [PINS-1:0] edge_lat_ff;
   logic [PINS-1:0] s1_ff, s2_ff, s3_ff, pin_ff;
   logic [11:0] awaddr_ff;
   logic [31:0] wdata_ff;
   logic [3:0] wstrb_ff;
   logic aw_have_ff, w_have_ff;
   logic bvalid_ff, rvalid_ff;
   logic [1:0] bresp_ff, rresp_ff;
   logic [31:0] rdata_ff;
   logic [PINS-1:0] rise, fall, edge_hit, lvl_hit, raw_status_bits, masked_status_bits;
   logic wr_fire;
   logic wr_hit, rd_hit;
   logic [31:0] rd_word;
   logic [PINS-1:0] clr_bits;

   // ------------------------------------------------------------
   // pin synchroniser, change accepted when stages 2 and 3 agree
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s1_ff <= '0;
         s2_ff <= '0;
         s3_ff <= '0;
         pin_ff <= '0;
      end else begin
         s1_ff <= pin_in;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         pin_ff <= (s2_ff & s3_ff) | (pin_ff & (s2_ff | s3_ff));
      end
   end

   // ------------------------------------------------------------
   // detection
   // ------------------------------------------------------------
   assign rise = ((s2_ff & s3_ff) | (pin_ff & (s2_ff | s3_ff))) & ~pin_ff;
   assign fall = pin_ff & ~(s2_ff | s3_ff) & ~(s2_ff & s3_ff);
   // edge selection by both-edges and polarity
   assign edge_hit = ~cfg_ff.sense & (rise & (cfg_ff.both | cfg_ff.pol)
                     | fall & (cfg_ff.both | ~cfg_ff.pol));
   // level selection by polarity
   assign lvl_hit = cfg_ff.sense & ~(pin_ff ^ cfg_ff.pol);
   // raw status: latch for edges, live for levels
   assign raw_status_bits = (edge_lat_ff & ~cfg_ff.sense) | lvl_hit;
   assign masked_status_bits = raw_status_bits & cfg_ff.mask;
   assign pin_irq = masked_status_bits;
   assign port_combined_irq = |masked_status_bits;
   assign hw_control_bits = fsel_ff;

   // ------------------------------------------------------------
   // axi write channel
   // ------------------------------------------------------------
   assign s_axi_awready = !aw_have_ff && !bvalid_ff;
   assign s_axi_wready = !w_have_ff && !bvalid_ff;
   assign wr_fire = aw_have_ff && w_have_ff && !bvalid_ff;
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;
   assign wr_hit = awaddr_ff == gpi_pkg::OFF_SENSE || awaddr_ff == gpi_pkg::OFF_BOTH
      || awaddr_ff == gpi_pkg::OFF_POL || awaddr_ff == gpi_pkg::OFF_MASK
      || awaddr_ff == gpi_pkg::OFF_CLR || awaddr_ff == gpi_pkg::OFF_FSEL
      || awaddr_ff == gpi_pkg::OFF_RAW || awaddr_ff == gpi_pkg::OFF_MSTAT;
   assign clr_bits = (wr_fire && awaddr_ff == gpi_pkg::OFF_CLR && wstrb_ff[0]) ? wdata_ff[PINS-1:0] : '0;

   // address/data capture in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_ff <= 1'b0;
         w_have_ff <= 1'b0;
         awaddr_ff <= 12'h0000;
         wdata_ff <= 32'h0000_0000;
         wstrb_ff <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_ff <= 1'b1;
            awaddr_ff <= {s_axi_awaddr[11:2], 2'b00};
         end else if (wr_fire) begin
            aw_have_ff <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_ff <= 1'b1;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
         end else if (wr_fire) begin
            w_have_ff <= 1'b0;
         end
      end
   end

   // write response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_ff <= 1'b0;
         bresp_ff <= gpi_pkg::RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_ff <= 1'b1;
         bresp_ff <= wr_hit ? gpi_pkg::RESP_OKAY : gpi_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_ff <= 1'b0;
      end
   end

   // configuration registers, low byte lane only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg_ff <= {4{gpi_pkg::RST_CFG}};
      end else if (wr_fire && wstrb_ff[0]) begin
         case (awaddr_ff)
            gpi_pkg::OFF_SENSE: cfg_ff.sense <= wdata_ff[7:0];
            gpi_pkg::OFF_BOTH: cfg_ff.both <= wdata_ff[7:0];
            gpi_pkg::OFF_POL: cfg_ff.pol <= wdata_ff[7:0];
            gpi_pkg::OFF_MASK: cfg_ff.mask <= wdata_ff[7:0];
            default: cfg_ff <= cfg_ff;
         endcase
      end
   end

   // function select, debug pins reset to hardware on any reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fsel_ff <= FSEL_RESET[PINS-1:0];
      end else if (wr_fire && wstrb_ff[0] && awaddr_ff == gpi_pkg::OFF_FSEL) begin
         fsel_ff <= wdata_ff[PINS-1:0];
      end
   end

   // edge latch: set wins over a clear in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         edge_lat_ff <= '0;
      end else begin
         edge_lat_ff <= (edge_lat_ff & ~clr_bits) | edge_hit;
      end
   end

   // ------------------------------------------------------------
   // axi read channel
   // ------------------------------------------------------------
   assign s_axi_arready = !rvalid_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata = rdata_ff;
   assign s_axi_rresp = rresp_ff;

   // read mux
   always_comb begin
      rd_word = 32'h0000_0000;
      rd_hit = 1'b1;
      case ({s_axi_araddr[11:2], 2'b00})
         gpi_pkg::OFF_SENSE: rd_word[7:0] = cfg_ff.sense;
         gpi_pkg::OFF_BOTH: rd_word[7:0] = cfg_ff.both;
         gpi_pkg::OFF_POL: rd_word[7:0] = cfg_ff.pol;
         gpi_pkg::OFF_MASK: rd_word[7:0] = cfg_ff.mask;
         gpi_pkg::OFF_RAW: rd_word[PINS-1:0] = raw_status_bits;
         gpi_pkg::OFF_MSTAT: rd_word[PINS-1:0] = masked_status_bits;
         gpi_pkg::OFF_CLR: rd_word = 32'h0000_0000;
         gpi_pkg::OFF_FSEL: rd_word[PINS-1:0] = fsel_ff;
         default: rd_hit = 1'b0;
      endcase
   end

   // read data register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
         rresp_ff <= gpi_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && !rvalid_ff) begin
         rvalid_ff <= 1'b1;
         rdata_ff <= rd_word;
         rresp_ff <= rd_hit ? gpi_pkg::RESP_OKAY : gpi_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_ff <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence clr_all_s;
      wr_fire && wstrb_ff[0] && awaddr_ff == gpi_pkg::OFF_CLR && wdata_ff[7:0] == 8'hff;
   endsequence

   masked_and_a: assert property (masked_status_bits == (raw_status_bits & cfg_ff.mask))
      else $error("masked status differs from raw and mask");
   comb_line_a: assert property (port_combined_irq == (masked_status_bits != '0))
      else $error("combined line wrong");
   mask_block_a: assert property (cfg_ff.mask == '0 |-> !port_combined_irq)
      else $error("masked pins raised interrupt");
   lvl_follow_a: assert property (cfg_ff.sense[0] |-> raw_status_bits[0] == (pin_ff[0] == cfg_ff.pol[0]))
      else $error("level raw status wrong");
   rise_latch_a: assert property (!cfg_ff.sense[0] && cfg_ff.pol[0] && rise[0] |=> edge_lat_ff[0])
      else $error("rising edge missed");
   fall_latch_a: assert property (!cfg_ff.sense[0] && cfg_ff.both[0] && fall[0] |=> edge_lat_ff[0])
      else $error("both-edge fall missed");
   edge_hold_a: assert property (edge_lat_ff[0] && clr_bits[0] == 1'b0 |=> edge_lat_ff[0])
      else $error("edge latch lost without clear");
   clr_latch_a: assert property (clr_all_s and (edge_hit == '0) |=> edge_lat_ff == '0)
      else $error("clear did not reset latch");
   fsel_rst_a: assert property ($rose(aresetn) |-> fsel_ff == FSEL_RESET[PINS-1:0])
      else $error("function select reset value wrong");
   cfg_rst_a: assert property ($rose(aresetn) |-> cfg_ff == {4{gpi_pkg::RST_CFG}})
      else $error("configuration reset value wrong");

   // ------------------------------------------------------------
   // synchroniser steps
   // ------------------------------------------------------------
   // late stages of pin 0 agreeing high or low
   sequence pin_up_s;
      s2_ff[0] && s3_ff[0];
   endsequence
   sequence pin_dn_s;
      !s2_ff[0] && !s3_ff[0];
   endsequence

   // agreed high stages move the filtered pin up
   sync_up_a: assert property (
      pin_up_s |=> pin_ff[0])
      else $error("synchronised pin did not rise");
   // agreed low stages move the filtered pin down
   sync_dn_a: assert property (
      pin_dn_s |=> !pin_ff[0])
      else $error("synchronised pin did not fall");
   // filtered pin moves only once the stages agree
   sync_agree_a: assert property (
      $changed(pin_ff[0]) |-> $past(s2_ff[0]) == $past(s3_ff[0]))
      else $error("synchronised pin moved without agreement");

   // ------------------------------------------------------------
   // detection steps
   // ------------------------------------------------------------
   // both-edges pin latches a rising edge
   both_rise_a: assert property (
      !cfg_ff.sense[0] && cfg_ff.both[0] && rise[0] |=> edge_lat_ff[0])
      else $error("both-edge rise missed");
   // polarity zero latches a falling edge
   fall_pol_a: assert property (
      !cfg_ff.sense[0] && !cfg_ff.pol[0] && fall[0] |=> edge_lat_ff[0])
      else $error("falling edge missed");
   // level pins never set the edge latch
   lvl_nolatch_a: assert property (
      cfg_ff.sense[0] && !edge_lat_ff[0] |=> !edge_lat_ff[0])
      else $error("level pin set edge latch");
   // no latch on an edge pin: raw reads zero
   raw_zero_a: assert property (
      !cfg_ff.sense[0] && !edge_lat_ff[0] |-> !raw_status_bits[0])
      else $error("raw status set without event");
   // masked pin keeps its own line low
   pin_mask_a: assert property (
      !cfg_ff.mask[0] |-> !pin_irq[0])
      else $error("masked pin raised its line");
   // clear write of zero keeps the latch
   clr_zero_a: assert property (
      wr_fire && awaddr_ff == gpi_pkg::OFF_CLR && !wdata_ff[0] && edge_lat_ff[0] |=> edge_lat_ff[0])
      else $error("zero clear dropped latch");

   // ------------------------------------------------------------
   // register bus steps
   // ------------------------------------------------------------
   // write taken with both halves, read address taken
   sequence wr_take_s;
      wr_fire;
   endsequence
   sequence rd_take_s;
      s_axi_arvalid && s_axi_arready;
   endsequence

   // response follows both halves
   wr_resp_a: assert property (
      wr_take_s |=> s_axi_bvalid)
      else $error("write response missing");
   // response stands until taken
   bresp_hold_a: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped early");
   // no response without a write
   bresp_none_a: assert property (
      !s_axi_bvalid && !wr_fire |=> !s_axi_bvalid)
      else $error("spurious write response");
   // read answers in the next cycle
   rd_resp_a: assert property (
      rd_take_s |=> s_axi_rvalid)
      else $error("read response missing");
   // read data stands until taken
   rdata_hold_a: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data changed while waiting");
   // raw read returns the raw bits
   raw_read_a: assert property (
      s_axi_arvalid && s_axi_arready && {s_axi_araddr[11:2], 2'b00} == gpi_pkg::OFF_RAW
      |=> s_axi_rdata[PINS-1:0] == $past(raw_status_bits))
      else $error("raw read data wrong");
   // mask write lands
   mask_wr_a: assert property (
      wr_take_s ##0 (wstrb_ff[0] && awaddr_ff == gpi_pkg::OFF_MASK) |=> cfg_ff.mask == $past(wdata_ff[7:0]))
      else $error("mask write lost");
   // sense write lands
   sense_wr_a: assert property (
      wr_take_s ##0 (wstrb_ff[0] && awaddr_ff == gpi_pkg::OFF_SENSE) |=> cfg_ff.sense == $past(wdata_ff[7:0]))
      else $error("sense write lost");
   // polarity write lands
   pol_wr_a: assert property (
      wr_take_s ##0 (wstrb_ff[0] && awaddr_ff == gpi_pkg::OFF_POL) |=> cfg_ff.pol == $past(wdata_ff[7:0]))
      else $error("polarity write lost");
   // both-edges write lands
   both_wr_a: assert property (
      wr_take_s ##0 (wstrb_ff[0] && awaddr_ff == gpi_pkg::OFF_BOTH) |=> cfg_ff.both == $past(wdata_ff[7:0]))
      else $error("both-edges write lost");
   // function select write lands
   fsel_wr_a: assert property (
      wr_take_s ##0 (wstrb_ff[0] && awaddr_ff == gpi_pkg::OFF_FSEL) |=> fsel_ff == $past(wdata_ff[PINS-1:0]))
      else $error("function select write lost");
endmodule // gpi_irq_port

// ==== sim/gpi_pin_model.sv ====
`timescale 1ns/1ns
// ------------------------------------------------------------
// board pins and interrupt controller
// ------------------------------------------------------------
module gpi_pin_model (
   // clock
   input wire logic aclk,
   // interrupt lines from the port
   input wire logic [7:0] pin_irq,
   input wire logic port_combined_irq,
   // pin levels towards the port
   output logic [7:0] pin_in
);
   logic prev_ff = 1'b0;
   int irq_rises = 0;
   initial pin_in = 8'h02;
   // pins change just after a clock edge
   task automatic drive(input logic [7:0] v);
      @(posedge aclk);
      pin_in <= v;
   endtask
   // count requests seen by the interrupt controller
   always @(posedge aclk) begin
      prev_ff <= port_combined_irq;
      if (port_combined_irq === 1'b1 && prev_ff === 1'b0) irq_rises++;
   end
endmodule // gpi_pin_model

// ==== sim/gpio_pin_interrupt_and_function_select_bench.sv ====
`timescale 1ns/1ns
module gpio_pin_interrupt_and_function_select_bench;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0000_0000;
   logic awready, wready, bvalid, arready, rvalid, combined;
   logic [1:0] bresp, rresp, resp;
   logic [31:0] rdata, val;
   logic [7:0] pins, hwc, pirq;
   logic [11:0] offs [4] = '{gpi_pkg::OFF_SENSE, gpi_pkg::OFF_BOTH, gpi_pkg::OFF_POL, gpi_pkg::OFF_MASK};
   int n_fail = 0, n_tests = 0, cycles = 0;
   always #10 aclk = ~aclk;
   gpi_irq_port #(.FSEL_RESET(8'h80)) u_dut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .pin_in(pins), .hw_control_bits(hwc), .pin_irq(pirq), .port_combined_irq(combined));
   gpi_pin_model u_pins (.aclk(aclk), .pin_irq(pirq), .port_combined_irq(combined), .pin_in(pins));
   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   // write: both channels offered together, each dropped once taken
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic ha, hw, hb;
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wvalid <= 1'b1;
      bready <= 1'b1;
      hb = 1'b0;
      while (!hb) begin
         @(negedge aclk);
         ha = awvalid & awready;
         hw = wvalid & wready;
         hb = bvalid & bready;
         resp = bresp;
         @(posedge aclk);
         if (ha) awvalid <= 1'b0;
         if (hw) wvalid <= 1'b0;
      end
   endtask
   task automatic rd(input logic [11:0] a);
      logic ha, hr;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      hr = 1'b0;
      while (!hr) begin
         @(negedge aclk);
         ha = arvalid & arready;
         hr = rvalid & rready;
         val = rdata;
         resp = rresp;
         @(posedge aclk);
         if (ha) arvalid <= 1'b0;
      end
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
      rd(a);
      check(val, exp);
   endtask
   // pins pass a three-flop synchroniser, then the latch
   task automatic pin_set(input logic [7:0] v);
      u_pins.drive(v);
      repeat (6) @(posedge aclk);
   endtask
   task automatic do_reset();
      aresetn <= 1'b0;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
   endtask
   task automatic complete_run();
      $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // hang guard
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 5000) begin
         n_fail++;
         complete_run();
      end
   end
   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial begin
      do_reset();
      for (int i = 0; i < 4; i++) rdc(offs[i], 32'h0000_0000);
      rdc(gpi_pkg::OFF_RAW, 32'h0000_0000);
      rdc(gpi_pkg::OFF_FSEL, 32'h0000_0080);
      check(hwc, 8'h80);
      $display("test reset values done");
      for (int i = 0; i < 4; i++) begin
         wr(offs[i], 32'h0000_00a5);
         rdc(offs[i], 32'h0000_00a5);
      end
      wr(12'h100, 32'h0000_00ff);
      check(resp, gpi_pkg::RESP_SLVERR);
      rd(12'h100);
      check(resp, gpi_pkg::RESP_SLVERR);
      $display("test register access done");
      // pin0 rising, pin1 falling, pin2 both edges, pin3 high level
      wr(gpi_pkg::OFF_SENSE, 32'h0000_0008);
      wr(gpi_pkg::OFF_BOTH, 32'h0000_0004);
      wr(gpi_pkg::OFF_POL, 32'h0000_0009);
      wr(gpi_pkg::OFF_MASK, 32'h0000_0000);
      pin_set(8'h05);
      rdc(gpi_pkg::OFF_RAW, 32'h0000_0007);
      rdc(gpi_pkg::OFF_MSTAT, 32'h0000_0000);
      check(combined, 1'b0);
      wr(gpi_pkg::OFF_MASK, 32'h0000_0007);
      rdc(gpi_pkg::OFF_MSTAT, 32'h0000_0007);
      check(pirq, 8'h07);
      check(combined, 1'b1);
      check(u_pins.irq_rises, 1);
      wr(gpi_pkg::OFF_CLR, 32'h0000_0000);
      rdc(gpi_pkg::OFF_RAW, 32'h0000_0007);
      wr(gpi_pkg::OFF_CLR, 32'h0000_0007);
      rdc(gpi_pkg::OFF_RAW, 32'h0000_0000);
      check(combined, 1'b0);
      pin_set(8'h00);
      rdc(gpi_pkg::OFF_RAW, 32'h0000_0004);
      pin_set(8'h08);
      rdc(gpi_pkg::OFF_RAW, 32'h0000_000c);
      pin_set(8'h00);
      rdc(gpi_pkg::OFF_RAW, 32'h0000_0004);
      $display("test detection done");
      wr(gpi_pkg::OFF_FSEL, 32'h0000_0001);
      rdc(gpi_pkg::OFF_FSEL, 32'h0000_0001);
      check(hwc, 8'h01);
      do_reset();
      check(hwc, 8'h80);
      rdc(gpi_pkg::OFF_MASK, 32'h0000_0000);
      $display("test function select done");
      complete_run();
   end
endmodule // gpio_pin_interrupt_and_function_select_bench
